// ===== core/radio_cfg_regs.vh
// Register offsets, reset values and field positions of the radio config bank
//
// Notes on behaviour
// - Modem family bit 7 of mode register changes only while sleeping.
// - Keying field bits 6-5: 00 FSK, 01 OOK, 10 and 11 reserved.
// - Mode bit 3 picks low or high band test bank from 0x61 up.
// - State field bits 2-0 encode sleep through receive; 111 reserved.
// - Symbol rate is crystal over divider plus fraction sixteenths.
// - Deviation word is upper bits 5-0 and lower byte; bits 7-6 reserved.
// - Reset reloads every register with its listed reset value.
// - Register 0x35 holds queue threshold and start condition, reset 0x0F.
// - 0x3E reports lock, timeout, signal flags; 0x3F FIFO and supply.
// - 0x40 maps pins zero to three, 0x41 maps pins four and five.
// - 0x42 returns a fixed silicon revision code.
`ifndef RADIO_CFG_REGS_VH
`define RADIO_CFG_REGS_VH
// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define A_FIFO 7'h00
`define A_OPMODE 7'h01
`define A_RATE_HI 7'h02
`define A_RATE_LO 7'h03
`define A_DEV_HI 7'h04
`define A_DEV_LO 7'h05
`define A_PKT2 7'h31
`define A_PAYLOAD 7'h32
`define A_NODE 7'h33
`define A_BCAST 7'h34
`define A_QTHR 7'h35
`define A_SEQ1 7'h36
`define A_SEQ2 7'h37
`define A_TRES 7'h38
`define A_T1 7'h39
`define A_T2 7'h3A
`define A_IMGCAL 7'h3B
`define A_TEMP 7'h3C
`define A_SUPPLY 7'h3D
`define A_FLAGS1 7'h3E
`define A_FLAGS2 7'h3F
`define A_MAP_LO 7'h40
`define A_MAP_HI 7'h41
`define A_REV 7'h42
`define A_HOP 7'h44
`define A_REFSEL 7'h4B
`define A_PAHI 7'h4D
`define A_OLDTEMP 7'h5B
`define A_FRAC 7'h5D
`define A_GREF 7'h61
`define A_GTH1 7'h62
`define A_GTH2 7'h63
`define A_GTH3 7'h64
`define A_SLOOP 7'h70
// ----------------------------------------------------------------------
// Reset values (unprinted ones taken as zero)
// ----------------------------------------------------------------------
`define R_OPMODE 8'h09
`define R_RATE_HI 8'h1A
`define R_RATE_LO 8'h0B
`define R_DEV_HI 8'h00
`define R_DEV_LO 8'h52
`define R_QTHR 8'h0F
`define R_IMGCAL 8'h82
`define R_FLAGS2 8'h40
`define R_HOP 8'h2D
`define R_REFSEL 8'h09
`define R_PAHI 8'h84
`define R_FRAC 8'h00
`define R_GREF 8'h13
`define R_GTH1 8'h0E
`define R_GTH2 8'h5B
`define R_SLOOP 8'hD0
`define R_ZERO 8'h00
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define B_SPREAD 7
`define B_LOWBAND 3
`define ST_SLEEP 3'h0
`define ST_RSVD7 3'h7
`define DEV_HI_MASK 8'h3F
`define FLAGS2_EMPTY_BIT 6
`define FLAGS2_FULL_BIT 7
`define F_KEY 6:5
`define F_STATE 2:0
`define B_RSVD4 4
`define F_FRAC 3:0
`define F_DEV_HI 5:0
`define R_STATE 3'h1
`define R_LOWBAND 1'h1
`endif

// ===== core/radio_config_register_bank.v
// Radio configuration register bank with Avalon-MM slave and data FIFO
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_regs.vh"
module radio_config_register_bank #(
    parameter FIFO_DEPTH = 64,
    parameter FIFO_AW = 6,
    parameter [7:0] REVISION_CODE = 8'hA5
) (
    input wire clk,
    input wire rst,
    input wire [6:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire [7:0] die_temperature,
    input wire [7:0] stored_cal_temperature,
    input wire [7:0] flags_one_in,
    input wire [3:0] flags_two_in,
    input wire [7:0] hf_test_data,
    input wire fifo_pop,
    output reg [7:0] fifo_head,
    output reg fifo_nonempty,
    output reg spread_modem_select_ff,
    output reg [1:0] keying_scheme_select_ff,
    output reg low_band_test_bank_ff,
    output reg [2:0] state_ff,
    output reg [15:0] symbol_rate_divider_ff,
    output reg [3:0] rate_fraction_ff,
    output reg [13:0] deviation_word_ff,
    output reg [7:0] queue_threshold_ff,
    output reg [15:0] pin_map_ff
);
// Revision value is arbitrary, not any real part's code

// ----------------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------------
reg [7:0] opmode_ff;
reg [7:0] rate_hi_ff;
reg [7:0] rate_lo_ff;
reg [7:0] dev_hi_ff;
reg [7:0] dev_lo_ff;
reg [7:0] pkt2_ff;
reg [7:0] payload_ff;
reg [7:0] node_ff;
reg [7:0] bcast_ff;
reg [7:0] qthr_ff;
reg [7:0] seq1_ff;
reg [7:0] seq2_ff;
reg [7:0] tres_ff;
reg [7:0] t1_ff;
reg [7:0] t2_ff;
reg [7:0] imgcal_ff;
reg [7:0] supply_ff;
reg [7:0] map_lo_ff;
reg [7:0] map_hi_ff;
reg [7:0] hop_ff;
reg [7:0] refsel_ff;
reg [7:0] pahi_ff;
reg [7:0] frac_ff;
reg [7:0] gref_ff;
reg [7:0] gth1_ff;
reg [7:0] gth2_ff;
reg [7:0] gth3_ff;
reg [7:0] sloop_ff;
reg done_ff;

// ----------------------------------------------------------------------
// FIFO
// ----------------------------------------------------------------------
reg [7:0] mem [0:FIFO_DEPTH-1];
reg [FIFO_AW-1:0] wp_ff;
reg [FIFO_AW-1:0] rp_ff;
reg [FIFO_AW:0] cnt_ff;

wire req = (read | write) & ~done_ff;
wire wr_en = write & req & byteenable[0];
wire rd_en = read & req;
wire [7:0] wd = writedata[7:0];
wire f_full = (cnt_ff == FIFO_DEPTH);
wire f_empty = (cnt_ff == 0);
// Push while full and pop while empty are dropped, not wrapped
wire push = wr_en & (address == `A_FIFO) & ~f_full;
wire bus_pop = rd_en & (address == `A_FIFO) & ~f_empty;
wire pop = bus_pop | (fifo_pop & ~f_empty & ~bus_pop);
wire [7:0] head = mem[rp_ff];

always @(posedge clk) begin
    if (push) begin
        mem[wp_ff] <= wd;
    end
end

always @(posedge clk) begin
    if (rst) begin
        wp_ff <= {FIFO_AW{1'b0}};
        rp_ff <= {FIFO_AW{1'b0}};
        cnt_ff <= {(FIFO_AW+1){1'b0}};
    end else begin
        if (push) begin
            wp_ff <= wp_ff + 1'b1;
        end
        if (pop) begin
            rp_ff <= rp_ff + 1'b1;
        end
        if (push & ~pop) begin
            cnt_ff <= cnt_ff + 1'b1;
        end else if (pop & ~push) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end
end

// ----------------------------------------------------------------------
// Mode register write filter
// ----------------------------------------------------------------------
reg [7:0] nxt_opmode;
always @* begin
    nxt_opmode = opmode_ff;
    nxt_opmode[`F_KEY] = wd[`F_KEY];
    nxt_opmode[`B_LOWBAND] = wd[`B_LOWBAND];
    // Reserved code would leave the state machine undefined; keep old
    if (wd[`F_STATE] != `ST_RSVD7) begin
        nxt_opmode[`F_STATE] = wd[`F_STATE];
    end
    if (opmode_ff[`F_STATE] == `ST_SLEEP) begin
        nxt_opmode[`B_SPREAD] = wd[`B_SPREAD];
    end
    nxt_opmode[`B_RSVD4] = 1'b0;
end

// ----------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        opmode_ff <= `R_OPMODE;
        rate_hi_ff <= `R_RATE_HI;
        rate_lo_ff <= `R_RATE_LO;
        dev_hi_ff <= `R_DEV_HI;
        dev_lo_ff <= `R_DEV_LO;
        pkt2_ff <= `R_ZERO;
        payload_ff <= `R_ZERO;
        node_ff <= `R_ZERO;
        bcast_ff <= `R_ZERO;
        qthr_ff <= `R_QTHR;
        seq1_ff <= `R_ZERO;
        seq2_ff <= `R_ZERO;
        tres_ff <= `R_ZERO;
        t1_ff <= `R_ZERO;
        t2_ff <= `R_ZERO;
        imgcal_ff <= `R_IMGCAL;
        supply_ff <= `R_ZERO;
        map_lo_ff <= `R_ZERO;
        map_hi_ff <= `R_ZERO;
        hop_ff <= `R_HOP;
        refsel_ff <= `R_REFSEL;
        pahi_ff <= `R_PAHI;
        frac_ff <= `R_FRAC;
        gref_ff <= `R_GREF;
        gth1_ff <= `R_GTH1;
        gth2_ff <= `R_GTH2;
        gth3_ff <= `R_ZERO;
        sloop_ff <= `R_SLOOP;
    end else if (wr_en) begin
        case (address)
            `A_OPMODE: opmode_ff <= nxt_opmode;
            `A_RATE_HI: rate_hi_ff <= wd;
            `A_RATE_LO: rate_lo_ff <= wd;
            `A_DEV_HI: dev_hi_ff <= wd;
            `A_DEV_LO: dev_lo_ff <= wd;
            `A_PKT2: pkt2_ff <= wd;
            `A_PAYLOAD: payload_ff <= wd;
            `A_NODE: node_ff <= wd;
            `A_BCAST: bcast_ff <= wd;
            `A_QTHR: qthr_ff <= wd;
            `A_SEQ1: seq1_ff <= wd;
            `A_SEQ2: seq2_ff <= wd;
            `A_TRES: tres_ff <= wd;
            `A_T1: t1_ff <= wd;
            `A_T2: t2_ff <= wd;
            `A_IMGCAL: imgcal_ff <= wd;
            `A_SUPPLY: supply_ff <= wd;
            `A_MAP_LO: map_lo_ff <= wd;
            `A_MAP_HI: map_hi_ff <= wd;
            `A_HOP: hop_ff <= wd;
            `A_REFSEL: refsel_ff <= wd;
            `A_PAHI: pahi_ff <= wd;
            `A_FRAC: frac_ff <= wd;
            // Low band bank only; high band bank is outside this block
            `A_GREF: begin
                if (opmode_ff[`B_LOWBAND]) begin
                    gref_ff <= wd;
                end
            end
            `A_GTH1: begin
                if (opmode_ff[`B_LOWBAND]) begin
                    gth1_ff <= wd;
                end
            end
            `A_GTH2: begin
                if (opmode_ff[`B_LOWBAND]) begin
                    gth2_ff <= wd;
                end
            end
            `A_GTH3: begin
                if (opmode_ff[`B_LOWBAND]) begin
                    gth3_ff <= wd;
                end
            end
            `A_SLOOP: begin
                if (opmode_ff[`B_LOWBAND]) begin
                    sloop_ff <= wd;
                end
            end
            // Unlisted test addresses and read-only ones ignore writes
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------------
wire [7:0] flags2 = {f_full, f_empty, 2'b00, flags_two_in};
wire lb = opmode_ff[`B_LOWBAND];
reg [7:0] rd_byte;
always @* begin
    case (address)
        `A_FIFO: rd_byte = head;
        `A_OPMODE: rd_byte = opmode_ff;
        `A_RATE_HI: rd_byte = rate_hi_ff;
        `A_RATE_LO: rd_byte = rate_lo_ff;
        `A_DEV_HI: rd_byte = dev_hi_ff;
        `A_DEV_LO: rd_byte = dev_lo_ff;
        `A_PKT2: rd_byte = pkt2_ff;
        `A_PAYLOAD: rd_byte = payload_ff;
        `A_NODE: rd_byte = node_ff;
        `A_BCAST: rd_byte = bcast_ff;
        `A_QTHR: rd_byte = qthr_ff;
        `A_SEQ1: rd_byte = seq1_ff;
        `A_SEQ2: rd_byte = seq2_ff;
        `A_TRES: rd_byte = tres_ff;
        `A_T1: rd_byte = t1_ff;
        `A_T2: rd_byte = t2_ff;
        `A_IMGCAL: rd_byte = imgcal_ff;
        `A_TEMP: rd_byte = die_temperature;
        `A_SUPPLY: rd_byte = supply_ff;
        `A_FLAGS1: rd_byte = flags_one_in;
        `A_FLAGS2: rd_byte = flags2;
        `A_MAP_LO: rd_byte = map_lo_ff;
        `A_MAP_HI: rd_byte = map_hi_ff;
        `A_REV: rd_byte = REVISION_CODE;
        `A_HOP: rd_byte = hop_ff;
        `A_REFSEL: rd_byte = refsel_ff;
        `A_PAHI: rd_byte = pahi_ff;
        `A_OLDTEMP: rd_byte = stored_cal_temperature;
        `A_FRAC: rd_byte = frac_ff;
        `A_GREF: rd_byte = lb ? gref_ff : hf_test_data;
        `A_GTH1: rd_byte = lb ? gth1_ff : hf_test_data;
        `A_GTH2: rd_byte = lb ? gth2_ff : hf_test_data;
        `A_GTH3: rd_byte = lb ? gth3_ff : hf_test_data;
        `A_SLOOP: rd_byte = lb ? sloop_ff : hf_test_data;
        default: rd_byte = `R_ZERO;
    endcase
end

// ----------------------------------------------------------------------
// Bus handshake: one wait cycle, answer on the second edge
// ----------------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        done_ff <= 1'b0;
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
    end else begin
        done_ff <= req;
        waitrequest <= ~req;
        if (rd_en) begin
            readdata <= {24'h000000, rd_byte};
        end
    end
end

// ----------------------------------------------------------------------
// Outputs to the datapath
// ----------------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        spread_modem_select_ff <= 1'b0;
        keying_scheme_select_ff <= 2'b00;
        low_band_test_bank_ff <= `R_LOWBAND;
        state_ff <= `R_STATE;
        symbol_rate_divider_ff <= {`R_RATE_HI, `R_RATE_LO};
        rate_fraction_ff <= 4'h0;
        deviation_word_ff <= 14'h0000;
        queue_threshold_ff <= `R_QTHR;
        pin_map_ff <= 16'h0000;
        fifo_head <= 8'h00;
        fifo_nonempty <= 1'b0;
    end else begin
        spread_modem_select_ff <= opmode_ff[`B_SPREAD];
        keying_scheme_select_ff <= opmode_ff[`F_KEY];
        low_band_test_bank_ff <= opmode_ff[`B_LOWBAND];
        state_ff <= opmode_ff[`F_STATE];
        symbol_rate_divider_ff <= {rate_hi_ff, rate_lo_ff};
        rate_fraction_ff <= frac_ff[`F_FRAC];
        deviation_word_ff <= {dev_hi_ff[`F_DEV_HI], dev_lo_ff};
        queue_threshold_ff <= qthr_ff;
        pin_map_ff <= {map_hi_ff, map_lo_ff};
        fifo_head <= head;
        fifo_nonempty <= ~f_empty;
    end
end
endmodule
`default_nettype wire

// ===== testbench/radio_cfg_asserts.sv
// Concurrent checks on the radio config register bank
`timescale 1ns/1ps
`default_nettype none
module radio_cfg_asserts #(
    parameter logic [7:0] REVISION_CODE = 8'hA5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic spread_modem_select_ff,
    input wire logic [1:0] keying_scheme_select_ff,
    input wire logic low_band_test_bank_ff,
    input wire logic [2:0] state_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Mode write completing; copies show it one edge later
    wire mw = write && !waitrequest && address == 7'h01;
    property p_spread_sleep;
        mw && state_ff == 3'h0 |->
            ##2 spread_modem_select_ff == $past(writedata[7], 2);
    endproperty
    a_spread_sleep: assert property (p_spread_sleep)
        else $error("modem select not taken in sleep");
    property p_spread_hold;
        mw && state_ff != 3'h0 |->
            ##2 spread_modem_select_ff == $past(spread_modem_select_ff, 2);
    endproperty
    a_spread_hold: assert property (p_spread_hold)
        else $error("modem select changed outside sleep");
    property p_keying;
        mw |-> ##2 keying_scheme_select_ff == $past(writedata[6:5], 2);
    endproperty
    a_keying: assert property (p_keying)
        else $error("keying field not stored");
    property p_band;
        mw |-> ##2 low_band_test_bank_ff == $past(writedata[3], 2);
    endproperty
    a_band: assert property (p_band)
        else $error("test bank bit not stored");
    property p_state;
        mw && writedata[2:0] != 3'h7 |->
            ##2 state_ff == $past(writedata[2:0], 2);
    endproperty
    a_state: assert property (p_state)
        else $error("state field not stored");
    property p_state_rsvd;
        mw && writedata[2:0] == 3'h7 |-> ##2 state_ff == $past(state_ff, 2);
    endproperty
    a_state_rsvd: assert property (p_state_rsvd)
        else $error("reserved state code accepted");
    property p_reset;
        $fell(rst) |-> state_ff == 3'h1 && low_band_test_bank_ff
            && !spread_modem_select_ff && waitrequest;
    endproperty
    a_reset: assert property (p_reset)
        else $error("mode outputs wrong after reset");
    property p_rev;
        read && !waitrequest && address == 7'h42 |->
            readdata == {24'h0, REVISION_CODE};
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision code read wrong");
endmodule
bind radio_config_register_bank radio_cfg_asserts #(
    .REVISION_CODE(REVISION_CODE)
) u_chk (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .state_ff(state_ff),
    .spread_modem_select_ff(spread_modem_select_ff),
    .keying_scheme_select_ff(keying_scheme_select_ff),
    .low_band_test_bank_ff(low_band_test_bank_ff));
`default_nettype wire

// ===== testbench/host_model.sv
// Host bus master model speaking Avalon-MM with waitrequest
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output var logic [6:0] address,
    output var logic read,
    output var logic write,
    output var logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic [31:0] readdata
);
    initial begin
        address = 7'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // Callers pass only listed addresses
    task wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, v};
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        write <= 1'b0;
        // Stale data must not look valid after release
        writedata <= ~{24'h0, v};
    endtask
    task rd(input logic [6:0] a, output logic [31:0] v);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        v = readdata;
        read <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/radio_config_register_bank_tb.sv
// Self-checking bench for the radio config register bank
`timescale 1ns/1ps
`default_nettype none
module radio_config_register_bank_tb;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary revision code
    logic clk, rst, fifo_pop, read, write, waitrequest, nonempty;
    logic spread, band;
    logic [6:0] address;
    logic [31:0] writedata, readdata, r;
    logic [7:0] head, qthr;
    logic [1:0] keying;
    logic [2:0] state;
    logic [15:0] rate, pmap;
    logic [3:0] frac, flags_two;
    logic [13:0] dev;
    int n_mismatch = 0;
    int n_tests = 0;
    radio_config_register_bank #(.REVISION_CODE(REV)) DUT (.clk(clk),
        .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .die_temperature(8'h5E),
        .stored_cal_temperature(8'h71), .flags_one_in(8'hC4),
        .flags_two_in(flags_two), .hf_test_data(8'h96),
        .fifo_pop(fifo_pop),
        .fifo_head(head), .fifo_nonempty(nonempty),
        .spread_modem_select_ff(spread), .keying_scheme_select_ff(keying),
        .low_band_test_bank_ff(band), .state_ff(state),
        .symbol_rate_divider_ff(rate), .rate_fraction_ff(frac),
        .deviation_word_ff(dev), .queue_threshold_ff(qthr),
        .pin_map_ff(pmap));
    host_model h (.clk(clk), .address(address), .read(read),
        .write(write), .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task t_reset;
        logic [15:0] t [14] = '{16'h0109, 16'h021A, 16'h030B, 16'h0400,
            16'h0552, 16'h350F, 16'h3B82, 16'h3F40, 16'h442D, 16'h4B09,
            16'h4D84, 16'h5D00, 16'h6213, 16'h70D0};
        foreach (t[i]) begin
            h.rd(t[i][14:8] == 7'h62 ? 7'h61 : t[i][14:8], r);
            chk(r, {24'h0, t[i][7:0]});
        end
        $display("reset values done");
    endtask
    task t_mode;
        logic [15:0] t [10] = '{16'h8000, 16'hA8A8, 16'h3F28, 16'hD5C5,
            16'h63E3, 16'h0282, 16'h0484, 16'h0686, 16'h0080, 16'h0101};
        foreach (t[i]) begin
            h.wr(7'h01, t[i][15:8]);
            h.rd(7'h01, r);
            chk(r, {24'h0, t[i][7:0]});
            chk({spread, keying, 1'b0, band, state}, t[i][7:0]);
        end
        $display("mode register done");
    endtask
    task t_values;
        // Threshold gets its recommended value
        logic [15:0] t [8] = '{16'h02C3, 16'h035A, 16'h5DF7, 16'h04FF,
            16'h0581, 16'h358F, 16'h405A, 16'h41C3};
        foreach (t[i]) h.wr(t[i][14:8], t[i][7:0]);
        h.wr(7'h3C, 8'h00);
        repeat (2) @(posedge clk);
        chk({frac, rate}, 20'h7C35A);
        chk(dev, 14'h3F81);
        chk(qthr, 8'h8F);
        chk(pmap, 16'hC35A);
        h.rd(7'h42, r);
        chk(r, {24'h0, REV});
        h.rd(7'h3E, r);
        chk(r, 32'hC4);
        flags_two <= 4'hA;
        h.rd(7'h3F, r);
        chk(r, 32'h4A);
        flags_two <= 4'h0;
        h.rd(7'h61, r);
        chk(r, 32'h96);
        h.rd(7'h3C, r);
        chk(r, 32'h5E);
        h.rd(7'h5B, r);
        chk(r, 32'h71);
        $display("value registers done");
    endtask
    task t_fifo;
        for (int i = 1; i < 4; i++) h.wr(7'h00, 8'h11 * i[7:0]);
        repeat (2) @(posedge clk);
        chk({nonempty, head}, 9'h111);
        fifo_pop <= 1'b1;
        @(posedge clk);
        fifo_pop <= 1'b0;
        for (int i = 2; i < 4; i++) begin
            h.rd(7'h00, r);
            chk(r, 8'h11 * i);
        end
        repeat (2) @(posedge clk);
        chk(nonempty, 0);
        h.rd(7'h3F, r);
        chk(r, 32'h40);
        $display("data queue done");
    endtask
    task close_out;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
    initial begin
        rst = 1'b1;
        fifo_pop = 1'b0;
        flags_two = 4'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_mode;
        t_values;
        // Second reset must undo everything programmed so far
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_fifo;
        close_out;
    end
endmodule
`default_nettype wire
